// File: design/cfg_loader_pkg.sv
// shared constants and types for the parallel flash configuration loader
package cfg_loader_pkg;

  localparam int ADDR_W          = 24;
  localparam int DATA_W          = 16;
  localparam int OSC_FREQ_MHZ    = 40;
  localparam int CFG_CLK_MAX_MHZ = 40;
  // oscillator cycles per config clock half period
  localparam int CFG_HALF_CYC    = 1;
  localparam int CFG_CLK_MHZ     = OSC_FREQ_MHZ / (2 * CFG_HALF_CYC);
  localparam int CNT_W           = 4;

  localparam int RST_PULSE_NS    = 100;
  localparam int RST_RECOV_NS    = 150;
  localparam int ACCESS_NS       = 100;

  // least time in ns to whole config clock periods, never below one
  function automatic int ns_to_ticks(input int ns, input int mhz);
    int t;
    t = (ns * mhz + 999) / 1000;
    return (t < 1) ? 1 : t;
  endfunction

  localparam logic [CNT_W-1:0] HALF_LAST =
    CNT_W'(CFG_HALF_CYC - 1);
  localparam logic [CNT_W-1:0] RST_PULSE_TICKS =
    CNT_W'(ns_to_ticks(RST_PULSE_NS, CFG_CLK_MHZ));
  localparam logic [CNT_W-1:0] RST_RECOV_TICKS =
    CNT_W'(ns_to_ticks(RST_RECOV_NS, CFG_CLK_MHZ));
  localparam logic [CNT_W-1:0] ACCESS_TICKS =
    CNT_W'(ns_to_ticks(ACCESS_NS, CFG_CLK_MHZ));
  localparam logic [ADDR_W:1]  ADDR_START = 24'h000000;

  typedef enum logic [2:0] {
    LD_IDLE,
    LD_RST_PULSE,
    LD_RST_WAIT,
    LD_ADDR,
    LD_READ,
    LD_HAND
  } load_state_e;

endpackage

// File: design/bit_sync.sv
// two flip-flop synchroniser for levels and toggles
`timescale 1ns/1ps
module bit_sync #(
  parameter int WIDTH = 1
) (
  // destination domain
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // asynchronous input and synchronised output
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // only the second stage is visible outside
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= d_i;
      sync_r <= meta_r;
    end
  end

  assign q_o = sync_r;

endmodule

// File: design/cfg_clock_div.sv
// config clock divider running on the internal oscillator
`timescale 1ns/1ps
module cfg_clock_div
  import cfg_loader_pkg::*;
(
  // oscillator domain
  input  wire logic clk_i,
  input  wire logic rst_i,
  // divided clock and step marker
  output logic      clk_o,
  output logic      step_o
);

  logic [CNT_W-1:0] half_r;
  logic             clk_r;
  wire              half_end;

  assign half_end = (half_r == HALF_LAST);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      half_r <= '0;
      clk_r  <= 1'b0;
    end else begin
      half_r <= half_end ? '0 : half_r + 1'b1;
      clk_r  <= clk_r ^ half_end;
    end
  end

  assign clk_o  = clk_r;
  // step on the falling edge so pins settle before the flash samples
  assign step_o = half_end & clk_r;

endmodule

// File: design/flash_config_loader.sv
// parallel flash configuration loader with chain hand-off
`timescale 1ns/1ps
// Behaviour
// - config clock comes from internal oscillator
// - config clock never exceeds forty megahertz
// - drive 24-bit word address from bit one
// - 16-bit two-way data bus with flash
// - loader ignores flash wait during configuration
// - drive active-low output enable strobe
// - drive active-low address-valid and write strobes
// - drive active-low hard reset and select
// - reads default asynchronous, writes always asynchronous
// - config clock times every interface transfer
// - own data captured drives chain output low
// - chain output becomes user io afterwards
// - first device master, others passive slaves
// - shared bus byte-wide or word-wide
// - hold done line low until data held
module flash_config_loader
  import cfg_loader_pkg::*;
(
  // system clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              rst_i,
  // internal configuration oscillator
  input  wire logic              osc_clk_i,
  // restart and chain pins
  input  wire logic              reconfig_request_n_i,
  input  wire logic              chain_enable_n_i,
  output logic                   chain_enable_n_o,
  input  wire logic              chain_user_io_i,
  // shared open-drain completion line
  input  wire logic              config_complete_line_i,
  output logic                   config_complete_line_o,
  output logic                   config_complete_line_oe_o,
  // flash control pins
  output logic                   config_clock_o,
  output logic [ADDR_W:1]        flash_addr_o,
  output logic                   flash_chip_select_n_o,
  output logic                   flash_output_enable_n_o,
  output logic                   flash_address_valid_n_o,
  output logic                   flash_write_strobe_n_o,
  output logic                   flash_hard_reset_n_o,
  output logic                   flash_ctrl_oe_o,
  // flash data pins
  input  wire logic [DATA_W-1:0] flash_data_i,
  output logic [DATA_W-1:0]      flash_data_o,
  output logic                   flash_data_oe_o,
  // configuration word stream to the core
  output logic [DATA_W-1:0]      cfg_word_o,
  output logic                   cfg_valid_o,
  input  wire logic              cfg_ready_i,
  input  wire logic              own_data_done_i,
  output logic                   init_mode_o
);

  // system domain: pins, chain and completion line

  logic [2:0]        pin_s;
  logic              req_s;
  logic              own_done_r;
  logic              run_r;
  logic              release_r;
  logic              chain_out_r;
  logic              line_oe_r;
  logic              init_r;
  logic              ack_tgl_r;
  logic              req_d_r;
  logic [DATA_W-1:0] cfg_word_r;
  // written on the oscillator side, held while the request toggle is open
  logic [DATA_W-1:0] word_r;
  logic              req_tgl_r;

  wire reconf_n_s;
  wire chain_en_n_s;
  wire line_s;
  wire own_done_nxt;
  wire run_nxt;
  wire release_nxt;
  wire chain_out_nxt;
  wire init_nxt;
  wire pending;
  wire word_new;
  wire word_ready;
  wire word_take;
  wire ack_tgl_nxt;

  bit_sync #(.WIDTH(3)) u_pin_sync (
    .clk_i (sys_clk_i),
    .rst_i (rst_i),
    .d_i   ({reconfig_request_n_i, chain_enable_n_i,
             config_complete_line_i}),
    .q_o   (pin_s)
  );

  assign reconf_n_s   = pin_s[2];
  assign chain_en_n_s = pin_s[1];
  assign line_s       = pin_s[0];

  // done is set by the core and dropped only by a restart; set wins
  assign own_done_nxt = own_data_done_i | (own_done_r & reconf_n_s);
  // first device sees its chain input held low and masters the bus
  assign run_nxt = reconf_n_s & ~chain_en_n_s & ~own_done_nxt;
  assign release_nxt = chain_en_n_s & ~reconf_n_s;
  // low once own data is in, user io after initialisation
  assign chain_out_nxt = init_r ? chain_user_io_i
                                : ~own_done_nxt;
  assign init_nxt = line_s & own_done_r & reconf_n_s;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      own_done_r  <= 1'b0;
      run_r       <= 1'b0;
      release_r   <= 1'b0;
      chain_out_r <= 1'b1;
      line_oe_r   <= 1'b1;
      init_r      <= 1'b0;
    end else begin
      own_done_r  <= own_done_nxt;
      run_r       <= run_nxt;
      release_r   <= release_nxt;
      chain_out_r <= chain_out_nxt;
      line_oe_r   <= ~own_done_nxt;
      init_r      <= init_nxt;
    end
  end

  assign chain_enable_n_o          = chain_out_r;
  assign config_complete_line_o    = 1'b0;
  assign config_complete_line_oe_o = line_oe_r;
  assign init_mode_o               = init_r;

  // word crossing: the oscillator side toggles a request and holds the
  // word steady until the acknowledge toggle returns
  bit_sync #(.WIDTH(1)) u_req_sync (
    .clk_i (sys_clk_i),
    .rst_i (rst_i),
    .d_i   (req_tgl_r),
    .q_o   (req_s)
  );

  assign pending    = req_s ^ ack_tgl_r;
  assign word_new   = req_s ^ req_d_r;
  assign word_ready = pending & ~word_new;
  assign cfg_valid_o = word_ready & run_r;
  // words left over after a restart or completion are discarded
  assign word_take   = word_ready & (cfg_ready_i | ~run_r);
  assign ack_tgl_nxt = ack_tgl_r ^ word_take;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_tgl_r  <= 1'b0;
      req_d_r    <= 1'b0;
      cfg_word_r <= '0;
    end else begin
      ack_tgl_r <= ack_tgl_nxt;
      req_d_r   <= req_s;
      if (word_new) begin
        cfg_word_r <= word_r;
      end
    end
  end

  // whole word handed on; slave byte or word split is board wiring
  assign cfg_word_o = cfg_word_r;

  // oscillator domain: config clock and flash reader

  logic              osc_rst_n;
  logic [2:0]        ctl_s;
  logic [DATA_W-1:0] data_s;
  logic              step;
  load_state_e       state_r;
  load_state_e       state_nxt;
  logic [CNT_W-1:0]  cnt_r;
  logic [CNT_W-1:0]  cnt_nxt;
  logic [ADDR_W:1]   addr_r;
  logic [ADDR_W:1]   addr_nxt;
  logic              hard_rst_n_r;
  logic              cs_n_r;
  logic              oe_n_r;
  logic              avd_n_r;
  logic              ctrl_oe_r;

  wire osc_rst;
  wire run_s;
  wire release_s;
  wire ack_s;
  wire cnt_last;
  wire capture;
  wire hard_rst_n_nxt;
  wire cs_n_nxt;
  wire oe_n_nxt;
  wire avd_n_nxt;

  bit_sync #(.WIDTH(1)) u_rst_sync (
    .clk_i (osc_clk_i),
    .rst_i (rst_i),
    .d_i   (1'b1),
    .q_o   (osc_rst_n)
  );

  assign osc_rst = ~osc_rst_n;

  bit_sync #(.WIDTH(3)) u_ctl_sync (
    .clk_i (osc_clk_i),
    .rst_i (osc_rst),
    .d_i   ({run_r, release_r, ack_tgl_r}),
    .q_o   (ctl_s)
  );

  assign run_s     = ctl_s[2];
  assign release_s = ctl_s[1];
  assign ack_s     = ctl_s[0];

  // flash data pins are sampled through two stages like any pin
  bit_sync #(.WIDTH(DATA_W)) u_data_sync (
    .clk_i (osc_clk_i),
    .rst_i (osc_rst),
    .d_i   (flash_data_i),
    .q_o   (data_s)
  );

  // halving the oscillator keeps the clock under the cap whatever the
  // flash grade; faster grades gain nothing here
  cfg_clock_div u_div (
    .clk_i  (osc_clk_i),
    .rst_i  (osc_rst),
    .clk_o  (config_clock_o),
    .step_o (step)
  );

  assign cnt_last = (cnt_r == 4'h1);
  // the state only moves on a config clock step
  assign capture = step & (state_r == LD_READ) & cnt_last;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    addr_nxt  = addr_r;
    if (step) begin
      case (state_r)
        LD_IDLE: begin
          if (run_s) begin
            state_nxt = LD_RST_PULSE;
            cnt_nxt   = RST_PULSE_TICKS;
            addr_nxt  = ADDR_START;
          end
        end
        LD_RST_PULSE: begin
          if (cnt_last) begin
            state_nxt = LD_RST_WAIT;
            cnt_nxt   = RST_RECOV_TICKS;
          end else begin
            cnt_nxt = cnt_r - 1'b1;
          end
        end
        LD_RST_WAIT: begin
          if (cnt_last) begin
            state_nxt = LD_ADDR;
          end else begin
            cnt_nxt = cnt_r - 1'b1;
          end
        end
        LD_ADDR: begin
          state_nxt = LD_READ;
          cnt_nxt   = ACCESS_TICKS;
        end
        LD_READ: begin
          // fixed access time, wait pin deliberately not looked at
          if (cnt_last) begin
            state_nxt = LD_HAND;
          end else begin
            cnt_nxt = cnt_r - 1'b1;
          end
        end
        LD_HAND: begin
          if (ack_s == req_tgl_r) begin
            if (run_s) begin
              state_nxt = LD_ADDR;
              addr_nxt  = addr_r + 1'b1;
            end else begin
              state_nxt = LD_IDLE;
            end
          end
        end
        default: begin
          state_nxt = LD_IDLE;
        end
      endcase
    end
  end

  assign hard_rst_n_nxt = (state_nxt != LD_RST_PULSE);
  assign cs_n_nxt  = ~((state_nxt == LD_ADDR) | (state_nxt == LD_READ)
                       | (state_nxt == LD_HAND));
  assign avd_n_nxt = (state_nxt != LD_ADDR);
  assign oe_n_nxt  = (state_nxt != LD_READ);

  always_ff @(posedge osc_clk_i or posedge osc_rst) begin
    if (osc_rst) begin
      state_r      <= LD_IDLE;
      cnt_r        <= '0;
      addr_r       <= ADDR_START;
      word_r       <= '0;
      req_tgl_r    <= 1'b0;
      hard_rst_n_r <= 1'b0;
      cs_n_r       <= 1'b1;
      oe_n_r       <= 1'b1;
      avd_n_r      <= 1'b1;
      ctrl_oe_r    <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      cnt_r        <= cnt_nxt;
      addr_r       <= addr_nxt;
      hard_rst_n_r <= hard_rst_n_nxt;
      cs_n_r       <= cs_n_nxt;
      oe_n_r       <= oe_n_nxt;
      avd_n_r      <= avd_n_nxt;
      ctrl_oe_r    <= ~release_s;
      if (capture) begin
        word_r    <= data_s;
        req_tgl_r <= ~req_tgl_r;
      end
    end
  end

  assign flash_addr_o            = addr_r;
  assign flash_chip_select_n_o   = cs_n_r;
  assign flash_output_enable_n_o = oe_n_r;
  assign flash_address_valid_n_o = avd_n_r;
  assign flash_hard_reset_n_o    = hard_rst_n_r;
  assign flash_ctrl_oe_o         = ctrl_oe_r;
  // the loader only reads; writes stay with user logic
  assign flash_write_strobe_n_o  = 1'b1;
  assign flash_data_o            = '0;
  assign flash_data_oe_o         = 1'b0;

  // checks

  a_clk_cap: assert property (
    @(posedge osc_clk_i) disable iff (osc_rst)
    $rose(config_clock_o) |=> !config_clock_o)
    else $error("config clock high longer than cap allows");

  a_clk_runs: assert property (
    @(posedge osc_clk_i) disable iff (osc_rst)
    !config_clock_o |=> config_clock_o)
    else $error("config clock stopped");

  a_addr_zero: assert property (
    @(posedge osc_clk_i) disable iff (osc_rst)
    (state_r == LD_RST_PULSE) |-> (flash_addr_o == ADDR_START))
    else $error("address not zero at start");

  a_addr_step: assert property (
    @(posedge osc_clk_i) disable iff (osc_rst)
    (state_r == LD_HAND && state_nxt == LD_ADDR)
      |=> (flash_addr_o == $past(flash_addr_o) + 1'b1))
    else $error("address did not step by one");

  a_read_frame: assert property (
    @(posedge osc_clk_i) disable iff (osc_rst)
    !flash_output_enable_n_o |-> !flash_chip_select_n_o
      && flash_address_valid_n_o && flash_hard_reset_n_o)
    else $error("output enable outside a selected read");

  a_avd_before_oe: assert property (
    @(posedge osc_clk_i) disable iff (osc_rst)
    $fell(flash_output_enable_n_o) |-> !$past(flash_address_valid_n_o))
    else $error("read without address valid first");

  a_no_write: assert property (
    @(posedge osc_clk_i) disable iff (osc_rst)
    flash_write_strobe_n_o && !flash_data_oe_o)
    else $error("loader drove a write");

  a_bus_release: assert property (
    @(posedge osc_clk_i) disable iff (osc_rst)
    release_s |=> !flash_ctrl_oe_o)
    else $error("bus not released");

  a_chain_low: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (own_data_done_i && !init_r) |=> !chain_enable_n_o)
    else $error("chain output not low after own data");

  a_line_held: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    !own_done_r |-> config_complete_line_oe_o)
    else $error("done line released before data held");

  a_valid_hold: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (cfg_valid_o && !cfg_ready_i && run_nxt)
      |=> cfg_valid_o && $stable(cfg_word_o))
    else $error("word dropped before it was taken");

  c_word_taken: cover property (
    @(posedge sys_clk_i) disable iff (rst_i)
    cfg_valid_o && cfg_ready_i);

  c_chain_hand: cover property (
    @(posedge sys_clk_i) disable iff (rst_i)
    $fell(chain_enable_n_o));

  c_init: cover property (
    @(posedge sys_clk_i) disable iff (rst_i)
    $rose(init_mode_o));

  c_release: cover property (
    @(posedge osc_clk_i) disable iff (osc_rst)
    $fell(flash_ctrl_oe_o));

endmodule

// File: dv/flash_model.sv
// partner model of the parallel flash: asynchronous word reads
`timescale 1ns/1ps
module flash_model
  import cfg_loader_pkg::*;
(
  // config clock from the loader: address latch and idle pattern
  input  wire logic              clk_i,
  // control and address pins from the loader
  input  wire logic              ctrl_oe_i,
  input  wire logic              hard_reset_n_i,
  input  wire logic              chip_select_n_i,
  input  wire logic              output_enable_n_i,
  input  wire logic              address_valid_n_i,
  // only the 24 word lines; a larger part's extra line is outside logic
  input  wire logic [ADDR_W:1]   addr_i,
  // read data and wait toward the loader
  output logic      [DATA_W-1:0] data_o,
  output logic                   wait_o
);
  logic [ADDR_W:1]   addr_r;
  logic [DATA_W-1:0] last_r = '0;
  wire               drive;

  // data and wait are driven only while selected and output-enabled
  assign drive = ctrl_oe_i & hard_reset_n_i & ~chip_select_n_i
               & ~output_enable_n_i;
  // released bus flips every cycle so a stale value can never be read
  assign data_o = drive ? {addr_r[8:1], ~addr_r[8:1]}
                        : ~last_r;
  // reads are asynchronous, so data is valid whenever it is driven
  assign wait_o = drive;

  // the part only moves on the rising config clock
  always_ff @(posedge clk_i) begin
    if (ctrl_oe_i && !address_valid_n_i) begin
      addr_r <= addr_i;
    end
    last_r <= data_o;
  end
endmodule

// File: dv/parallel_flash_config_loader_test.sv
// self-checking bench for the parallel flash configuration loader
`timescale 1ns/1ps
module parallel_flash_config_loader_test;
  import cfg_loader_pkg::*;

  logic              sys_clk_i = 0;
  logic              osc_clk   = 0;
  logic              rst_i     = 1;
  logic              reconfig_n, chain_n_in, user_io, done_in, ready;
  logic              others_low;
  logic              chain_n_out, line_o, line_oe, cfg_clk, cs_n, oe_n;
  logic              avd_n, write_n, hard_n, ctrl_oe, data_oe;
  logic              cfg_valid, init_mode;
  logic [ADDR_W:1]   flash_addr;
  logic [DATA_W-1:0] fl_data, dut_data, cfg_word;
  wire               line;
  time               last_rise = 0, clk_period = 0;
  int                bad_count, checks;

  initial begin
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    #7;
    forever #15 osc_clk = ~osc_clk;
  end

  // open-drain done line with pull-up; other slaves may hold it low
  assign line = ~line_oe & ~others_low;

  always @(posedge cfg_clk) begin
    clk_period = $time - last_rise;
    last_rise = $time;
  end

  flash_config_loader dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .osc_clk_i(osc_clk),
    .reconfig_request_n_i(reconfig_n), .chain_enable_n_i(chain_n_in),
    .chain_enable_n_o(chain_n_out), .chain_user_io_i(user_io),
    .config_complete_line_i(line), .config_complete_line_o(line_o),
    .config_complete_line_oe_o(line_oe), .config_clock_o(cfg_clk),
    .flash_addr_o(flash_addr), .flash_chip_select_n_o(cs_n),
    .flash_output_enable_n_o(oe_n), .flash_address_valid_n_o(avd_n),
    .flash_write_strobe_n_o(write_n), .flash_hard_reset_n_o(hard_n),
    .flash_ctrl_oe_o(ctrl_oe), .flash_data_i(fl_data),
    .flash_data_o(dut_data), .flash_data_oe_o(data_oe),
    .cfg_word_o(cfg_word), .cfg_valid_o(cfg_valid),
    .cfg_ready_i(ready), .own_data_done_i(done_in),
    .init_mode_o(init_mode)
  );

  flash_model flash (
    .clk_i(cfg_clk), .ctrl_oe_i(ctrl_oe), .hard_reset_n_i(hard_n),
    .chip_select_n_i(cs_n), .output_enable_n_i(oe_n),
    .address_valid_n_i(avd_n), .addr_i(flash_addr), .data_o(fl_data),
    .wait_o()
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  function automatic logic probe(input int sel);
    case (sel)
      0: return cfg_valid;
      1: return init_mode;
      2: return chain_n_out;
      default: return ctrl_oe;
    endcase
  endfunction

  // bounded wait; running out is a mismatch and ends the run
  task automatic wait_for(input int sel, input logic val, input int bound);
    for (int i = 0; i < bound; i++) begin
      @(negedge sys_clk_i);
      if (probe(sel) === val) return;
    end
    check(probe(sel), val);
    tally_and_finish();
  endtask

  task automatic reset_values;
    @(negedge sys_clk_i);
    check({chain_n_out, line_oe, write_n, hard_n, cfg_valid, ctrl_oe,
           init_mode}, 7'h70);
    check({cs_n, oe_n, avd_n}, 3'h7);
    check(flash_addr, 0);
    check({line_o, data_oe, dut_data}, 0);
  endtask

  // a stalled word must stand unchanged until it is taken
  task automatic take_word(input int k, input int stall);
    logic [15:0] exp;
    exp = {k[7:0], ~k[7:0]};
    wait_for(0, 1'b1, 400);
    check(cfg_word, exp);
    check({hard_n, write_n, ctrl_oe}, 3'h7);
    repeat (stall) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    check({cfg_valid, cfg_word}, {1'b1, exp});
    @(posedge sys_clk_i) ready <= 1;
    @(posedge sys_clk_i) ready <= 0;
    @(negedge sys_clk_i);
    check(cfg_valid, 0);
  endtask

  task automatic stream_words;
    @(posedge sys_clk_i) reconfig_n <= 1;
    for (int k = 0; k < 4; k++) begin
      take_word(k, (k == 1) ? 40 : 0);
    end
    // config clock is the oscillator halved and stays under the cap
    check(clk_period, 60);
    check(clk_period >= 1000 / CFG_CLK_MAX_MHZ, 1);
  endtask

  task automatic own_done_handoff;
    @(posedge sys_clk_i) done_in <= 1;
    @(posedge sys_clk_i) done_in <= 0;
    @(negedge sys_clk_i);
    check({chain_n_out, line_oe}, 2'h0);
    repeat (10) @(negedge sys_clk_i);
    check({init_mode, cfg_valid}, 2'h0);
    @(posedge sys_clk_i) others_low <= 0;
    wait_for(1, 1'b1, 10);
    check(init_mode, 1);
    @(posedge sys_clk_i) user_io <= 1;
    wait_for(2, 1'b1, 5);
    @(posedge sys_clk_i) user_io <= 0;
    wait_for(2, 1'b0, 5);
    check(chain_n_out, 0);
  endtask

  task automatic restart_from_zero;
    @(posedge sys_clk_i) begin
      reconfig_n <= 0;
      others_low <= 1;
    end
    repeat (40) @(negedge sys_clk_i);
    check({chain_n_out, line_oe, init_mode, ctrl_oe}, 4'hD);
    @(posedge sys_clk_i) reconfig_n <= 1;
    take_word(0, 0);
    take_word(1, 0);
  endtask

  task automatic release_bus;
    @(posedge sys_clk_i) begin
      reconfig_n <= 0;
      chain_n_in <= 1;
    end
    wait_for(3, 1'b0, 40);
    check(ctrl_oe, 0);
  endtask

  initial begin
    reconfig_n = 0;
    chain_n_in = 0;
    user_io = 0;
    done_in = 0;
    ready = 0;
    others_low = 1;
    bad_count = 0;
    checks = 0;
    // oscillator side resets asynchronously, so no osc edges are needed
    repeat (5) @(posedge sys_clk_i);
    reset_values();
    @(posedge sys_clk_i) rst_i <= 0;
    stream_words();
    own_done_handoff();
    restart_from_zero();
    release_bus();
    tally_and_finish();
  end
endmodule
